// ---- src/cpu_flags_and_address_modes.v ----
// Condition flags and operand effective-address datapath behind APB
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`include "cpu_flags_defines.vh"

module cpu_flags_and_address_modes (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        irq_req,
  output wire        irq_accept,
  output reg  [7:0]  flag_register,
  output reg  [15:0] eff_addr,
  output reg         mem_access
);

  // One-hot states of the post-increment sequencer
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_INC  = 2'b10;

  reg [7:0]  flags_r, flags_nxt;
  reg [7:0]  opa_r, opb_r;
  reg [7:0]  result_r, result_nxt;
  reg [15:0] ptr_r, ptr_nxt;
  reg [15:0] pc_r, pc_nxt;
  reg [15:0] ea_nxt;
  reg [15:0] lit_r, lit_nxt;
  reg        mem_nxt;
  reg        inhibit_r, inhibit_nxt;
  reg [1:0]  state_r, state_nxt;
  reg [2:0]  sync_r;
  reg        irq_lvl_r;
  reg [31:0] rdata_nxt;

  wire       wr_en  = psel & penable & pwrite;
  wire       hit    = (paddr == `OFS_FLAGS) || (paddr == `OFS_OPND) ||
                      (paddr == `OFS_CMD) || (paddr == `OFS_RESULT) ||
                      (paddr == `OFS_PTR) || (paddr == `OFS_PC) ||
                      (paddr == `OFS_ACMD) || (paddr == `OFS_EA) ||
                      (paddr == `OFS_LIT) || (paddr == `OFS_STATUS);
  wire       cmd_wr = wr_en && (paddr == `OFS_CMD);
  wire       acm_wr = wr_en && (paddr == `OFS_ACMD);
  wire [3:0] op     = pwdata[3:0];
  wire [2:0] mode   = pwdata[2:0];
  wire [7:0] byte0  = pwdata[15:8];
  wire [7:0] byte1  = pwdata[23:16];
  wire       cond   = pwdata[24];

  // Zero-wait slave; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // 8-bit add with carry in: {carry out, nibble carry, sum}
  function [9:0] add8;
    input [7:0] x;
    input [7:0] y;
    input       ci;
    reg   [8:0] s;
    reg   [4:0] lo;
    begin
      s    = {1'b0, x} + {1'b0, y} + {8'h00, ci};
      lo   = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
      add8 = {s[8], lo[4], s[7:0]};
    end
  endfunction

  // Signed overflow of x + y giving r
  function ovf;
    input [7:0] x;
    input [7:0] y;
    input [7:0] r;
    begin
      ovf = (x[7] == y[7]) && (r[7] != x[7]);
    end
  endfunction

  // Forces the constant-one bits of the flag image
  function [7:0] fix_ones;
    input [7:0] f;
    begin
      fix_ones = f | `FLAG_ONES;
    end
  endfunction

  // Interrupt pin synchroniser, three stages
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r    <= 3'b000;
      irq_lvl_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], irq_req};
      // Only accept a level once stages two and three agree
      if (sync_r[1] == sync_r[2])
        irq_lvl_r <= sync_r[2];
    end
  end

  // Recognition gated by mask and the post-clear shadow
  // mask blocks requests
  assign irq_accept = irq_lvl_r & ~flags_r[`FLG_I] & ~inhibit_r;

  // Flag and result logic for commands and flag writes
  always @* begin : alu
    reg [9:0] s;
    reg [7:0] a;
    reg [7:0] b;
    reg [7:0] corr;
    reg       cout;
    s           = 10'h000;
    a           = opa_r;
    b           = opb_r;
    corr        = `ZERO8;
    cout        = 1'b0;
    flags_nxt   = flags_r;
    result_nxt  = result_r;
    inhibit_nxt = inhibit_r;
    if (wr_en && (paddr == `OFS_FLAGS)) begin
      flags_nxt = fix_ones(pwdata[7:0]);
      inhibit_nxt = flags_r[`FLG_I] & ~pwdata[`FLG_I];
    end else if (cmd_wr) begin
      // Any new instruction except CLI ends the shadow
      inhibit_nxt = 1'b0;
      case (op)
        `OP_ADD, `OP_ADC: begin
          s = add8(a, b, (op == `OP_ADC) & flags_r[`FLG_C]);
          result_nxt = s[7:0];
          flags_nxt[`FLG_V] = ovf(a, b, s[7:0]);
          flags_nxt[`FLG_H] = s[8];
          flags_nxt[`FLG_C] = s[9];
        end
        `OP_SUB, `OP_SBC: begin
          // Subtract as a + ~b + ~borrow; nibble carry untouched
          s = add8(a, ~b, ~((op == `OP_SBC) & flags_r[`FLG_C]));
          result_nxt = s[7:0];
          flags_nxt[`FLG_V] = ovf(a, ~b, s[7:0]);
          flags_nxt[`FLG_C] = ~s[9];
        end
        `OP_AND: begin
          result_nxt = a & b;
          flags_nxt[`FLG_V] = 1'b0;
        end
        `OP_LD8: begin
          result_nxt = a;
          flags_nxt[`FLG_V] = 1'b0;
        end
        `OP_LD16: begin
          result_nxt = a;
          flags_nxt[`FLG_V] = 1'b0;
        end
        `OP_DAA: begin
          // correction from nibble carry and carry-out
          if (flags_r[`FLG_H] || (a[3:0] > `BCD_LO_MAX))
            corr = corr | `BCD_LO_FIX;
          cout = flags_r[`FLG_C] || (a > `BCD_MAX);
          if (cout)
            corr = corr | `BCD_HI_FIX;
          s = add8(a, corr, 1'b0);
          result_nxt = s[7:0];
          flags_nxt[`FLG_C] = cout;
        end
        `OP_LSL: begin
          result_nxt = {a[6:0], 1'b0};
          flags_nxt[`FLG_C] = a[7];
          flags_nxt[`FLG_V] = a[6] ^ a[7];
        end
        `OP_ROL: begin
          result_nxt = {a[6:0], flags_r[`FLG_C]};
          flags_nxt[`FLG_C] = a[7];
          flags_nxt[`FLG_V] = a[6] ^ a[7];
        end
        `OP_BTST: begin
          flags_nxt[`FLG_C] = a[b[2:0]];
        end
        `OP_CLI: begin
          flags_nxt[`FLG_I] = 1'b0;
          inhibit_nxt = flags_r[`FLG_I];
        end
        `OP_SEI: flags_nxt[`FLG_I] = 1'b1;
        `OP_INT: begin
          flags_nxt[`FLG_I] = 1'b1;
        end
        default: ;
      endcase
      // Msb-set and all-clear follow the produced or moved value
      if (op == `OP_LD16) begin
        flags_nxt[`FLG_N] = b[7];
        flags_nxt[`FLG_Z] = ({b, a} == `ZERO16);
      end else if ((op <= `OP_ROL) && (op != `OP_LD16)) begin
        flags_nxt[`FLG_N] = result_nxt[7];
        flags_nxt[`FLG_Z] = (result_nxt == `ZERO8);
      end
    end
    flags_nxt = fix_ones(flags_nxt);
  end

  // Effective address, literal, program counter and pointer
  always @* begin
    ea_nxt    = eff_addr;
    mem_nxt   = mem_access;
    lit_nxt   = lit_r;
    pc_nxt    = pc_r;
    ptr_nxt   = ptr_r;
    state_nxt = state_r;
    if (wr_en && (paddr == `OFS_PC))
      pc_nxt = pwdata[15:0];
    if (wr_en && (paddr == `OFS_PTR))
      ptr_nxt = pwdata[15:0];
    case (state_r)
      ST_INC: begin
        ptr_nxt   = ptr_r + `PTR_STEP;
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (acm_wr) begin
      // every mode yields one 16-bit address
      case (mode)
        `MODE_INH: begin
          ea_nxt  = `ZERO16;
          mem_nxt = 1'b0;
        end
        `MODE_REL: begin
          if (cond)
            ea_nxt = pc_r + {{8{byte0[7]}}, byte0};
          else
            ea_nxt = pc_r;
          pc_nxt  = ea_nxt;
          mem_nxt = 1'b0;
        end
        `MODE_IMM: begin
          ea_nxt  = pc_r;
          lit_nxt = {byte0, byte1};
          mem_nxt = 1'b1;
        end
        `MODE_DIR: begin
          ea_nxt  = {`DIR_PAGE, byte0};
          mem_nxt = 1'b1;
        end
        `MODE_EXT: begin
          ea_nxt  = {byte0, byte1};
          mem_nxt = 1'b1;
        end
        `MODE_IX: begin
          ea_nxt  = ptr_r;
          mem_nxt = 1'b1;
        end
        `MODE_IXP: begin
          ea_nxt    = ptr_r;
          mem_nxt   = 1'b1;
          state_nxt = ST_INC;
        end
        `MODE_IX1: begin
          ea_nxt  = ptr_r + {8'h00, byte0};
          mem_nxt = 1'b1;
        end
        default: begin
          ea_nxt  = `ZERO16;
          mem_nxt = 1'b0;
        end
      endcase
    end
  end

  // Register update, state cleared by reset except flags, which load FLAG_RESET, and the sequencer, which loads ST_IDLE
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r    <= `FLAG_RESET;
      opa_r      <= `ZERO8;
      opb_r      <= `ZERO8;
      result_r   <= `ZERO8;
      ptr_r      <= `ZERO16;
      pc_r       <= `ZERO16;
      eff_addr   <= `ZERO16;
      lit_r      <= `ZERO16;
      mem_access <= 1'b0;
      inhibit_r  <= 1'b0;
      state_r    <= ST_IDLE;
    end else begin
      flags_r    <= flags_nxt;
      result_r   <= result_nxt;
      ptr_r      <= ptr_nxt;
      pc_r       <= pc_nxt;
      eff_addr   <= ea_nxt;
      lit_r      <= lit_nxt;
      mem_access <= mem_nxt;
      inhibit_r  <= inhibit_nxt;
      state_r    <= state_nxt;
      if (wr_en && (paddr == `OFS_OPND)) begin
        opa_r <= pwdata[7:0];
        opb_r <= pwdata[15:8];
      end
    end
  end

  // Flag image output mirrors the stored flags
  always @* begin
    flag_register = flags_r;
  end

  // Read mux, loaded in the setup cycle; unmapped and reserved bits read zero
  always @* begin
    rdata_nxt = prdata;
    if (psel && !penable) begin
      case (paddr)
        `OFS_FLAGS:  rdata_nxt = {24'h00_0000, fix_ones(flags_r)};
        `OFS_OPND:   rdata_nxt = {16'h0000, opb_r, opa_r};
        `OFS_RESULT: rdata_nxt = {24'h00_0000, result_r};
        `OFS_PTR:    rdata_nxt = {16'h0000, ptr_r};
        `OFS_PC:     rdata_nxt = {16'h0000, pc_r};
        `OFS_EA:     rdata_nxt = {15'h0000, mem_access, eff_addr};
        `OFS_LIT:    rdata_nxt = {16'h0000, lit_r};
        `OFS_STATUS: rdata_nxt = {28'h000_0000, state_r[1], irq_accept,
                                  inhibit_r, irq_lvl_r};
        default:     rdata_nxt = `ZERO32;
      endcase
    end
  end

  // Read data from a flop; no write lands between setup and access edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `ZERO32;
    end else begin
      prdata <= rdata_nxt;
    end
  end

endmodule // cpu_flags_and_address_modes

// ---- src/cpu_flags_defines.vh ----
// Constants for the flag and address-mode datapath
`ifndef CPU_FLAGS_DEFINES_VH
`define CPU_FLAGS_DEFINES_VH
// APB register byte offsets
`define OFS_FLAGS   8'h00
`define OFS_OPND    8'h04
`define OFS_CMD     8'h08
`define OFS_RESULT  8'h0C
`define OFS_PTR     8'h10
`define OFS_PC      8'h14
`define OFS_ACMD    8'h18
`define OFS_EA      8'h1C
`define OFS_LIT     8'h20
`define OFS_STATUS  8'h24
// Flag register bit positions
`define FLG_V 7
`define FLG_K6 6
`define FLG_K5 5
`define FLG_H 4
`define FLG_I 3
`define FLG_N 2
`define FLG_Z 1
`define FLG_C 0
`define FLAG_RESET  8'h68
`define FLAG_ONES   8'h60
// Operation codes, CMD bits 3:0
`define OP_ADD   4'h0
`define OP_ADC   4'h1
`define OP_SUB   4'h2
`define OP_SBC   4'h3
`define OP_AND   4'h4
`define OP_LD8   4'h5
`define OP_LD16  4'h6
`define OP_DAA   4'h7
`define OP_LSL   4'h8
`define OP_ROL   4'h9
`define OP_BTST  4'hA
`define OP_CLI   4'hB
`define OP_SEI   4'hC
`define OP_INT   4'hD
// Address modes, ACMD bits 2:0
`define MODE_INH 3'h0
`define MODE_REL 3'h1
`define MODE_IMM 3'h2
`define MODE_DIR 3'h3
`define MODE_EXT 3'h4
`define MODE_IX  3'h5
`define MODE_IXP 3'h6
`define MODE_IX1 3'h7
// Datapath constants
`define DIR_PAGE    8'h00
`define PTR_STEP    16'h0001
`define BCD_LO_FIX  8'h06
`define BCD_HI_FIX  8'h60
`define BCD_LO_MAX  4'h9
`define BCD_MAX     8'h99
`define ZERO8       8'h00
`define ZERO16      16'h0000
`define ZERO32      32'h0000_0000
`endif

// ---- tb/cpu_flags_asserts.sv ----
// Port-level assertions for the flag and address-mode datapath
`timescale 1ns/100ps
`include "cpu_flags_defines.vh"
module cpu_flags_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        irq_req,
  input wire        irq_accept,
  input wire [7:0]  flag_register,
  input wire [15:0] eff_addr,
  input wire        mem_access
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Decoded bus events
  wire acc  = psel && penable;
  wire mode = acc && pwrite && (paddr == `OFS_ACMD);
  wire cmd  = acc && pwrite && (paddr == `OFS_CMD);
  a_ones_held:
    assert property (flag_register[6:5] == 2'b11) else $error("flag bits 6 and 5 not one");
  a_mask_blocks:
    assert property (flag_register[`FLG_I] |-> !irq_accept) else $error("accepted while masked");
  a_clear_shadow:
    assert property ($fell(flag_register[`FLG_I]) |-> !irq_accept [*2])
    else $error("accepted right after mask clear");
  // Zero wait answer
  a_zero_wait:
    assert property (acc |-> pready) else $error("pready low in access phase");
  // Unmapped access refused
  a_unmapped_err:
    assert property (acc && (paddr > `OFS_STATUS) |-> pslverr && (prdata == `ZERO32))
    else $error("unmapped access not refused");
  a_dir_page:
    assert property (mode && (pwdata[2:0] == `MODE_DIR)
      |=> mem_access && (eff_addr == {`DIR_PAGE, $past(pwdata[15:8])}))
    else $error("direct address wrong");
  a_ext_order:
    assert property (mode && (pwdata[2:0] == `MODE_EXT)
      |=> eff_addr == {$past(pwdata[15:8]), $past(pwdata[23:16])})
    else $error("extended address wrong");
  a_inh_nomem:
    assert property (mode && (pwdata[2:0] == `MODE_INH) |=> !mem_access)
    else $error("register-only mode flags memory access");
  a_int_mask:
    assert property (cmd && (pwdata[3:0] == `OP_INT) |=> flag_register[`FLG_I] [*2])
    else $error("mask not set on interrupt entry");
endmodule // cpu_flags_asserts

bind cpu_flags_and_address_modes cpu_flags_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_req(irq_req), .irq_accept(irq_accept), .flag_register(flag_register),
  .eff_addr(eff_addr), .mem_access(mem_access));

// ---- tb/tb.sv ----
// Self-checking bench for the flag and address-mode datapath
`timescale 1ns/100ps
`include "cpu_flags_defines.vh"
module tb;
  logic        pclk      = 1'b0;
  logic        presetn   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic        irq_req   = 1'b0;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq_accept, mem_access;
  wire  [7:0]  flag_register;
  wire  [15:0] eff_addr;
  logic [31:0] rd;
  logic        err;
  int          error_cnt = 0;
  int          checked   = 0;
  // 10 MHz core clock
  always #50 pclk = ~pclk;
  cpu_flags_and_address_modes DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_req(irq_req), .irq_accept(irq_accept),
    .flag_register(flag_register), .eff_addr(eff_addr), .mem_access(mem_access));
  // Verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Value compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // APB transfer; idle edge after it so strobes never toggle twice in a step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 20) begin
      error_cnt++;
      report_and_stop();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  // Flag operation: load flags and operands, run, read back
  task automatic op(input logic [3:0] c, input logic [7:0] a, input logic [7:0] b,
                    input logic [7:0] f, input logic [15:0] r, input logic [7:0] e);
    xfer(1'b1, `OFS_FLAGS, {24'h00_0000, f});
    xfer(1'b1, `OFS_OPND, {16'h0000, b, a});
    xfer(1'b1, `OFS_CMD, {28'h000_0000, c});
    rdchk(`OFS_FLAGS, {24'h00_0000, e}, "flags");
    chk("flag port", {24'h00_0000, e}, {24'h00_0000, flag_register});
    if (c <= `OP_ROL) begin
      rdchk(`OFS_RESULT, {16'h0000, r}, "result");
    end
  endtask
  // Address mode request and masked address readback
  task automatic am(input logic [2:0] m, input logic [7:0] b0, input logic [7:0] b1,
                    input logic cnd, input logic [31:0] e, input logic [31:0] k);
    xfer(1'b1, `OFS_ACMD, {7'h00, cnd, b1, b0, 5'h00, m});
    xfer(1'b0, `OFS_EA, 32'h0000_0000);
    chk("ea", e & k, rd & k);
    chk("ea port", e & k, {15'h0000, mem_access, eff_addr} & k);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(`OFS_FLAGS, 32'h0000_0068, "flags reset");
    rdchk(`OFS_PTR, 32'h0000_0000, "ptr reset");
    rdchk(`OFS_EA, 32'h0000_0000, "ea reset");
    xfer(1'b1, `OFS_FLAGS, 32'h0000_0008);
    rdchk(`OFS_FLAGS, 32'h0000_0068, "flags ones");
    op(`OP_ADD, 8'h08, 8'h08, 8'h68, 16'h0010, 8'h78);
    op(`OP_ADD, 8'h7F, 8'h01, 8'h68, 16'h0080, 8'hFC);
    op(`OP_ADD, 8'hFF, 8'h01, 8'h68, 16'h0000, 8'h7B);
    op(`OP_ADC, 8'h00, 8'h00, 8'h69, 16'h0001, 8'h68);
    op(`OP_SUB, 8'h00, 8'h01, 8'h68, 16'h00FF, 8'h6D);
    op(`OP_SUB, 8'h80, 8'h01, 8'h68, 16'h007F, 8'hE8);
    op(`OP_SBC, 8'h05, 8'h05, 8'h69, 16'h00FF, 8'h6D);
    op(`OP_AND, 8'hF0, 8'h0F, 8'hE8, 16'h0000, 8'h6A);
    op(`OP_LD8, 8'h80, 8'h00, 8'hE9, 16'h0080, 8'h6D);
    // Result register keeps the low byte of a 16-bit move
    op(`OP_LD16, 8'h00, 8'h01, 8'h6A, 16'h0000, 8'h68);
    op(`OP_LD16, 8'h00, 8'h80, 8'h6A, 16'h0000, 8'h6C);
    op(`OP_DAA, 8'h9A, 8'h00, 8'h68, 16'h0000, 8'h6B);
    op(`OP_DAA, 8'h13, 8'h00, 8'h78, 16'h0019, 8'h78);
    op(`OP_LSL, 8'hC0, 8'h00, 8'h68, 16'h0080, 8'h6D);
    op(`OP_ROL, 8'h00, 8'h00, 8'h69, 16'h0001, 8'h68);
    op(`OP_BTST, 8'h04, 8'h02, 8'h68, 16'h0000, 8'h69);
    op(`OP_BTST, 8'h04, 8'h03, 8'h69, 16'h0000, 8'h68);
    op(`OP_SEI, 8'h00, 8'h00, 8'h60, 16'h0000, 8'h68);
    // Interrupt gating
    irq_req <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("accept masked", 32'h0000_0000, {31'h0000_0000, irq_accept});
    xfer(1'b1, `OFS_CMD, {28'h000_0000, `OP_CLI});
    repeat (4) @(posedge pclk);
    chk("accept shadow", 32'h0000_0000, {31'h0000_0000, irq_accept});
    xfer(1'b1, `OFS_CMD, 32'h0000_000F);
    chk("accept open", 32'h0000_0001, {31'h0000_0000, irq_accept});
    xfer(1'b1, `OFS_CMD, {28'h000_0000, `OP_INT});
    chk("accept entry", 32'h0000_0000, {31'h0000_0000, irq_accept});
    rdchk(`OFS_FLAGS, 32'h0000_0068, "mask entry");
    irq_req <= 1'b0;
    // Address modes, flags must stay put
    xfer(1'b1, `OFS_FLAGS, 32'h0000_00F9);
    xfer(1'b1, `OFS_PTR, 32'h0000_FFF0);
    xfer(1'b1, `OFS_PC, 32'h0000_1000);
    am(`MODE_INH, 8'h00, 8'h00, 1'b0, 32'h0000_0000, 32'h0001_0000);
    am(`MODE_DIR, 8'h5A, 8'h77, 1'b0, 32'h0001_005A, 32'h0001_FFFF);
    am(`MODE_EXT, 8'h12, 8'h34, 1'b0, 32'h0001_1234, 32'h0001_FFFF);
    am(`MODE_IMM, 8'hAB, 8'hCD, 1'b0, 32'h0000_1000, 32'h0000_FFFF);
    rdchk(`OFS_LIT, 32'h0000_ABCD, "literal");
    am(`MODE_REL, 8'hF0, 8'h00, 1'b1, 32'h0000_0FF0, 32'h0000_FFFF);
    rdchk(`OFS_PC, 32'h0000_0FF0, "pc taken");
    am(`MODE_REL, 8'h05, 8'h00, 1'b0, 32'h0000_0FF0, 32'h0000_FFFF);
    xfer(1'b1, `OFS_PC, 32'h0000_FFF8);
    am(`MODE_REL, 8'h10, 8'h00, 1'b1, 32'h0000_0008, 32'h0000_FFFF);
    am(`MODE_IX, 8'h33, 8'h00, 1'b0, 32'h0001_FFF0, 32'h0001_FFFF);
    am(`MODE_IX1, 8'hFF, 8'h00, 1'b0, 32'h0001_00EF, 32'h0001_FFFF);
    am(`MODE_IXP, 8'h00, 8'h00, 1'b0, 32'h0001_FFF0, 32'h0001_FFFF);
    rdchk(`OFS_PTR, 32'h0000_FFF1, "ptr step");
    rdchk(`OFS_FLAGS, 32'h0000_00F9, "flags kept");
    // Unmapped place refused
    xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk("slverr", 32'h0000_0001, {31'h0000_0000, err});
    rdchk(8'h40, 32'h0000_0000, "unmapped data");
    // Second reset mid-run
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(`OFS_FLAGS, 32'h0000_0068, "flags rereset");
    rdchk(`OFS_PTR, 32'h0000_0000, "ptr rereset");
    rdchk(`OFS_EA, 32'h0000_0000, "ea rereset");
    report_and_stop();
  end
endmodule // tb
